// file: src/index_register_address_unit_consts.svh
// Constants for the index register address unit
`ifndef INDEX_REGISTER_ADDRESS_UNIT_CONSTS_SVH
`define INDEX_REGISTER_ADDRESS_UNIT_CONSTS_SVH

`define PTR_COUNT      16
`define PTR_IDX_W      4
`define ADDR_W         32
`define DR_W           16
`define OP_W           4
`define MODE_W         3
`define PTR_RESET      32'h0000_0000
`define STEP_ONE       32'h0000_0001
`define STEP_TWO       32'h0000_0002
`define PV_AREA_BASE   32'h0000_0000
`define LEGACY_OFFSET  32'h0000_0000

`endif

// file: src/index_register_address_unit_pkg.sv
// Types for the index register address unit
`default_nettype none
`include "index_register_address_unit_consts.svh"
package index_register_address_unit_pkg;

    typedef logic [`ADDR_W-1:0] addr_t;

    typedef enum logic [`OP_W-1:0] {
        OP_NONE        = 4'h0,
        OP_INDIRECT    = 4'h1,
        OP_LOAD_ADDR   = 4'h2,
        OP_LOAD_PV     = 4'h3,
        OP_SET_RECORD  = 4'h4,
        OP_GET_RECORD  = 4'h5,
        OP_MOVE        = 4'h6,
        OP_EXCHANGE    = 4'h7,
        OP_COMPARE     = 4'h8,
        OP_INC         = 4'h9,
        OP_DEC         = 4'ha,
        OP_ADD         = 4'hb,
        OP_SUB         = 4'hc,
        OP_FROM_LEGACY = 4'hd,
        OP_TO_LEGACY   = 4'he,
        OP_OTHER       = 4'hf
    } op_e;

    typedef enum logic [`MODE_W-1:0] {
        MODE_PLAIN     = 3'h0,
        MODE_CONST_OFF = 3'h1,
        MODE_DR_OFF    = 3'h2,
        MODE_POST_INC1 = 3'h3,
        MODE_POST_INC2 = 3'h4,
        MODE_PRE_DEC1  = 3'h5,
        MODE_PRE_DEC2  = 3'h6,
        MODE_RSVD      = 3'h7
    } mode_e;

endpackage : index_register_address_unit_pkg
`default_nettype wire

// file: src/index_register_address_unit.sv
// Index register file with indirect operand address generation
`timescale 1ns/1ns
`default_nettype none
`include "index_register_address_unit_consts.svh"

module index_register_address_unit
    import index_register_address_unit_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   req_valid,
    input  wire logic [`OP_W-1:0]       req_op,
    input  wire logic [`MODE_W-1:0]     req_mode,
    input  wire logic                   req_direct,
    input  wire logic [`PTR_IDX_W-1:0]  ptr_a,
    input  wire logic [`PTR_IDX_W-1:0]  ptr_b,
    input  wire logic [`ADDR_W-1:0]     const_offset,
    input  wire logic [`DR_W-1:0]       offset_data_reg,
    input  wire logic [`ADDR_W-1:0]     operand_addr,
    input  wire logic [`ADDR_W-1:0]     operand_data,
    output logic                        mem_req_reg,
    output logic [`ADDR_W-1:0]          mem_addr_reg,
    output logic                        result_valid_reg,
    output logic [`ADDR_W-1:0]          result_data_reg,
    output logic                        cmp_eq_reg,
    output logic                        cmp_lt_reg,
    output logic                        cmp_gt_reg,
    output logic                        illegal_reg
);

    addr_t index_pointer_reg  [`PTR_COUNT];
    addr_t index_pointer_next [`PTR_COUNT];
    addr_t ptr_a_val;
    addr_t ptr_b_val;
    addr_t dr_ext;
    logic  pointer_op;
    logic  accepted;
    logic  mem_req_next;
    addr_t mem_addr_next;
    logic  result_valid_next;
    addr_t result_data_next;
    logic  cmp_eq_next;
    logic  cmp_lt_next;
    logic  cmp_gt_next;
    logic  illegal_next;

    assign ptr_a_val = index_pointer_reg[ptr_a];
    assign ptr_b_val = index_pointer_reg[ptr_b];
    assign dr_ext    = {{(`ADDR_W-`DR_W){offset_data_reg[`DR_W-1]}},
                        offset_data_reg};

    // Direct naming is only legal for the pointer-handling opcodes
    assign pointer_op = (req_op != OP_NONE) && (req_op != OP_INDIRECT)
                        && (req_op != OP_OTHER);
    assign accepted   = req_valid && (pointer_op || !req_direct);

    always_comb begin
        for (int i = 0; i < `PTR_COUNT; i++) begin
            index_pointer_next[i] = index_pointer_reg[i];
        end
        mem_req_next      = 1'b0;
        mem_addr_next     = mem_addr_reg;
        result_valid_next = 1'b0;
        result_data_next  = result_data_reg;
        cmp_eq_next       = cmp_eq_reg;
        cmp_lt_next       = cmp_lt_reg;
        cmp_gt_next       = cmp_gt_reg;
        illegal_next      = req_valid && !accepted;
        if (accepted) begin
            unique case (op_e'(req_op))
                OP_INDIRECT: begin
                    mem_req_next = (req_mode != MODE_RSVD);
                    illegal_next = (req_mode == MODE_RSVD);
                    unique case (mode_e'(req_mode))
                        MODE_PLAIN: mem_addr_next = ptr_a_val;
                        MODE_CONST_OFF:
                            mem_addr_next = ptr_a_val + const_offset;
                        MODE_DR_OFF:
                            mem_addr_next = ptr_a_val + dr_ext;
                        MODE_POST_INC1: begin
                            mem_addr_next = ptr_a_val;
                            index_pointer_next[ptr_a] =
                                ptr_a_val + `STEP_ONE;
                        end
                        MODE_POST_INC2: begin
                            mem_addr_next = ptr_a_val;
                            index_pointer_next[ptr_a] =
                                ptr_a_val + `STEP_TWO;
                        end
                        MODE_PRE_DEC1: begin
                            mem_addr_next = ptr_a_val - `STEP_ONE;
                            index_pointer_next[ptr_a] =
                                ptr_a_val - `STEP_ONE;
                        end
                        MODE_PRE_DEC2: begin
                            mem_addr_next = ptr_a_val - `STEP_TWO;
                            index_pointer_next[ptr_a] =
                                ptr_a_val - `STEP_TWO;
                        end
                        MODE_RSVD: mem_addr_next = mem_addr_reg;
                    endcase
                end
                // Any bit, word or PV address is accepted unchanged
                OP_LOAD_ADDR:
                    index_pointer_next[ptr_a] = operand_addr;
                OP_LOAD_PV:
                    index_pointer_next[ptr_a] =
                        `PV_AREA_BASE + operand_addr;
                OP_SET_RECORD, OP_GET_RECORD: begin
                    result_valid_next = 1'b1;
                    result_data_next  = ptr_a_val;
                end
                OP_MOVE: index_pointer_next[ptr_a] = ptr_b_val;
                OP_EXCHANGE: begin
                    index_pointer_next[ptr_a] = ptr_b_val;
                    index_pointer_next[ptr_b] = ptr_a_val;
                end
                OP_COMPARE: begin
                    cmp_eq_next = (ptr_a_val == ptr_b_val);
                    cmp_lt_next = (ptr_a_val < ptr_b_val);
                    cmp_gt_next = (ptr_a_val > ptr_b_val);
                end
                OP_INC:
                    index_pointer_next[ptr_a] =
                        ptr_a_val + `STEP_ONE;
                OP_DEC:
                    index_pointer_next[ptr_a] =
                        ptr_a_val - `STEP_ONE;
                OP_ADD:
                    index_pointer_next[ptr_a] =
                        ptr_a_val + operand_data;
                OP_SUB:
                    index_pointer_next[ptr_a] =
                        ptr_a_val - operand_data;
                OP_FROM_LEGACY: begin
                    result_valid_next = 1'b1;
                    result_data_next  =
                        operand_data + `LEGACY_OFFSET;
                end
                OP_TO_LEGACY: begin
                    result_valid_next = 1'b1;
                    result_data_next  =
                        operand_data - `LEGACY_OFFSET;
                end
                OP_NONE, OP_OTHER: illegal_next = 1'b0;
            endcase
        end
    end

    // Sixteen 32-bit pointers, each one double-length value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `PTR_COUNT; i++) begin
                index_pointer_reg[i] <= `PTR_RESET;
            end
            mem_req_reg      <= 1'b0;
            mem_addr_reg     <= `PTR_RESET;
            result_valid_reg <= 1'b0;
            result_data_reg  <= `PTR_RESET;
            cmp_eq_reg       <= 1'b0;
            cmp_lt_reg       <= 1'b0;
            cmp_gt_reg       <= 1'b0;
            illegal_reg      <= 1'b0;
        end else begin
            for (int i = 0; i < `PTR_COUNT; i++) begin
                index_pointer_reg[i] <= index_pointer_next[i];
            end
            mem_req_reg      <= mem_req_next;
            mem_addr_reg     <= mem_addr_next;
            result_valid_reg <= result_valid_next;
            result_data_reg  <= result_data_next;
            cmp_eq_reg       <= cmp_eq_next;
            cmp_lt_reg       <= cmp_lt_next;
            cmp_gt_reg       <= cmp_gt_next;
            illegal_reg      <= illegal_next;
        end
    end

    logic ind_req;
    assign ind_req = req_valid && !req_direct && (req_op == OP_INDIRECT);

    // All checks run on the one clock and pause while reset is low
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_plain_access: assert property (
        ind_req && req_mode == MODE_PLAIN |=>
            mem_req_reg && mem_addr_reg == $past(ptr_a_val))
        else $error("plain indirect address wrong");

    a_const_offset: assert property (
        ind_req && req_mode == MODE_CONST_OFF |=>
            mem_addr_reg == $past(ptr_a_val) + $past(const_offset))
        else $error("constant offset address wrong");

    a_dr_offset: assert property (
        ind_req && req_mode == MODE_DR_OFF |=>
            mem_addr_reg == $past(ptr_a_val) + $past(dr_ext))
        else $error("data register offset address wrong");

    a_post_inc: assert property (
        ind_req && req_mode == MODE_POST_INC2 |=>
            mem_addr_reg == $past(ptr_a_val)
            && index_pointer_reg[$past(ptr_a)] == $past(ptr_a_val) + 32'h2)
        else $error("post increment wrong");

    a_pre_dec: assert property (
        ind_req && req_mode == MODE_PRE_DEC1 |=>
            mem_addr_reg == $past(ptr_a_val) - 32'h1
            && index_pointer_reg[$past(ptr_a)] == mem_addr_reg)
        else $error("pre decrement wrong");

    a_direct_refused: assert property (
        req_valid && req_direct && !pointer_op |=>
            illegal_reg && !mem_req_reg && !result_valid_reg)
        else $error("illegal direct naming not refused");

    a_load_addr: assert property (
        req_valid && req_op == OP_LOAD_ADDR |=>
            index_pointer_reg[$past(ptr_a)] == $past(operand_addr))
        else $error("load address not stored");

    a_record_out: assert property (
        req_valid && req_op == OP_GET_RECORD |=>
            result_valid_reg && result_data_reg == $past(ptr_a_val))
        else $error("record output wrong");

    a_exchange: assert property (
        req_valid && req_op == OP_EXCHANGE && ptr_a != ptr_b |=>
            index_pointer_reg[$past(ptr_a)] == $past(ptr_b_val)
            && index_pointer_reg[$past(ptr_b)] == $past(ptr_a_val))
        else $error("exchange wrong");

    a_compare: assert property (
        req_valid && req_op == OP_COMPARE |=>
            cmp_eq_reg == ($past(ptr_a_val) == $past(ptr_b_val))
            && cmp_lt_reg == ($past(ptr_a_val) < $past(ptr_b_val)))
        else $error("compare flags wrong");

    a_add_offset: assert property (
        req_valid && req_op == OP_ADD |=>
            index_pointer_reg[$past(ptr_a)]
                == $past(ptr_a_val) + $past(operand_data))
        else $error("pointer add wrong");

    a_to_legacy: assert property (
        req_valid && req_op == OP_TO_LEGACY |=>
            result_valid_reg
            && result_data_reg == $past(operand_data) - `LEGACY_OFFSET)
        else $error("legacy conversion wrong");

endmodule : index_register_address_unit
`default_nettype wire

// file: testbench/iru_memory_model.sv
// Word-addressed memory standing behind the address unit
`timescale 1ns/1ns
`default_nettype none
`include "index_register_address_unit_consts.svh"

module iru_memory_model (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              mem_req_reg,
    input  wire logic [`ADDR_W-1:0] mem_addr_reg,
    output logic [`ADDR_W-1:0]     last_addr,
    output logic [15:0]            n_access,
    output logic [15:0]            rd_word
);
    logic [15:0] mem [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(~i);
        end
    end

    // Only a real access updates the log; read data is junk otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_addr <= '0;
            n_access  <= '0;
            rd_word   <= 16'h5a5a;
        end else if (mem_req_reg) begin
            last_addr <= mem_addr_reg;
            n_access  <= n_access + 16'h0001;
            rd_word   <= mem[mem_addr_reg[7:0]];
        end else begin
            rd_word   <= ~rd_word;
        end
    end
endmodule : iru_memory_model
`default_nettype wire

// file: testbench/index_register_address_unit_tb.sv
// Self-checking bench for the index register address unit
`timescale 1ns/1ns
`default_nettype none
`include "index_register_address_unit_consts.svh"

module index_register_address_unit_tb
    import index_register_address_unit_pkg::*;
;
    logic clk, rstn, req_valid, req_direct;
    logic [3:0] req_op, ptr_a, ptr_b;
    logic [2:0] req_mode;
    logic [31:0] const_offset, operand_addr, operand_data;
    logic [15:0] offset_data_reg;
    logic mem_req_reg, result_valid_reg, cmp_eq_reg, cmp_lt_reg;
    logic cmp_gt_reg, illegal_reg;
    logic [31:0] mem_addr_reg, result_data_reg, last_addr;
    logic [15:0] n_access, rd_word;
    int n_fail = 0, checks = 0, cycles = 0;

    index_register_address_unit i_dut (.clk(clk), .rstn(rstn),
        .req_valid(req_valid), .req_op(req_op), .req_mode(req_mode),
        .req_direct(req_direct), .ptr_a(ptr_a), .ptr_b(ptr_b),
        .const_offset(const_offset), .offset_data_reg(offset_data_reg),
        .operand_addr(operand_addr), .operand_data(operand_data),
        .mem_req_reg(mem_req_reg), .mem_addr_reg(mem_addr_reg),
        .result_valid_reg(result_valid_reg),
        .result_data_reg(result_data_reg), .cmp_eq_reg(cmp_eq_reg),
        .cmp_lt_reg(cmp_lt_reg), .cmp_gt_reg(cmp_gt_reg),
        .illegal_reg(illegal_reg));
    iru_memory_model i_mem (.clk(clk), .rstn(rstn),
        .mem_req_reg(mem_req_reg), .mem_addr_reg(mem_addr_reg),
        .last_addr(last_addr), .n_access(n_access), .rd_word(rd_word));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk

    // One request, taken at the next edge, results sampled after it
    task automatic send(input logic [3:0] op, input logic dir,
                        input logic [3:0] a, input logic [31:0] v = 0,
                        input logic [2:0] m = 0, input logic [3:0] b = 0);
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_direct <= dir;
        ptr_a <= a;
        ptr_b <= b;
        req_mode <= m;
        const_offset <= v;
        operand_addr <= v;
        operand_data <= v;
        offset_data_reg <= v[15:0];
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
    endtask : send

    task automatic get(input logic [3:0] p, input logic [31:0] e);
        send(OP_GET_RECORD, 1'b1, p);
        chk("result_valid_reg", 1, result_valid_reg);
        chk("pointer", e, result_data_reg);
    endtask : get

    task automatic t_load();
        send(OP_LOAD_ADDR, 1'b1, 4'hf, 32'h1234_5678);
        get(4'hf, 32'h1234_5678);
        send(OP_LOAD_PV, 1'b1, 4'h0, 32'h0000_0040);
        get(4'h0, `PV_AREA_BASE + 32'h0000_0040);
        send(OP_SET_RECORD, 1'b1, 4'hf);
        chk("result_valid_reg", 1, result_valid_reg);
        chk("set_record", 32'h1234_5678, result_data_reg);
    endtask : t_load

    task automatic t_indirect();
        logic [2:0] md [7] = '{MODE_PLAIN, MODE_CONST_OFF, MODE_DR_OFF,
            MODE_POST_INC1, MODE_POST_INC2, MODE_PRE_DEC1, MODE_PRE_DEC2};
        logic [31:0] va [7] = '{0, 32'hffff_fffc, 32'h0000_fffe, 0, 0, 0, 0};
        logic [31:0] ea [7] = '{'h100, 'hfc, 'hfe, 'h100, 'h101, 'h102, 'h100};
        logic [31:0] ep [7] = '{'h100, 'h100, 'h100, 'h101, 'h103, 'h102,
                                'h100};
        send(OP_LOAD_ADDR, 1'b1, 4'h3, 32'h0000_0100);
        for (int i = 0; i < 7; i++) begin
            send(OP_INDIRECT, 1'b0, 4'h3, va[i], md[i]);
            chk("mem_req_reg", 1, mem_req_reg);
            chk("mem_addr_reg", ea[i], mem_addr_reg);
            get(4'h3, ep[i]);
            chk("last_addr", ea[i], last_addr);
            // One idle edge after the access inverts the model's word once
            chk("rd_word", {24'h0, ea[i][7:0]}, rd_word);
        end
        send(OP_INDIRECT, 1'b0, 4'h3, 0, MODE_RSVD);
        chk("illegal_reg", 1, illegal_reg);
        chk("mem_req_reg", 0, mem_req_reg);
        chk("n_access", 7, n_access);
        chk("last_addr", 32'h0000_0100, last_addr);
    endtask : t_indirect

    task automatic t_refuse();
        logic [3:0] ops [3] = '{OP_NONE, OP_INDIRECT, OP_OTHER};
        send(OP_LOAD_ADDR, 1'b1, 4'h6, 32'h0000_0055);
        foreach (ops[i]) begin
            send(ops[i], 1'b1, 4'h6, 32'h0000_0099);
            chk("illegal_reg", 1, illegal_reg);
            chk("mem_req_reg", 0, mem_req_reg);
        end
        send(OP_OTHER, 1'b0, 4'h6, 32'h0000_0099);
        chk("illegal_reg", 0, illegal_reg);
        get(4'h6, 32'h0000_0055);
    endtask : t_refuse

    task automatic t_move_cmp();
        send(OP_LOAD_ADDR, 1'b1, 4'h1, 32'hffff_0000);
        send(OP_LOAD_ADDR, 1'b1, 4'h2, 32'h0000_0001);
        send(OP_MOVE, 1'b1, 4'h4, 0, 0, 4'h1);
        get(4'h4, 32'hffff_0000);
        send(OP_EXCHANGE, 1'b1, 4'h1, 0, 0, 4'h2);
        get(4'h1, 32'h0000_0001);
        get(4'h2, 32'hffff_0000);
        send(OP_COMPARE, 1'b1, 4'h1, 0, 0, 4'h2);
        chk("cmp_flags", 3'b010, {cmp_eq_reg, cmp_lt_reg, cmp_gt_reg});
        send(OP_COMPARE, 1'b1, 4'h2, 0, 0, 4'h1);
        chk("cmp_flags", 3'b001, {cmp_eq_reg, cmp_lt_reg, cmp_gt_reg});
        send(OP_COMPARE, 1'b1, 4'h2, 0, 0, 4'h4);
        chk("cmp_flags", 3'b100, {cmp_eq_reg, cmp_lt_reg, cmp_gt_reg});
    endtask : t_move_cmp

    task automatic t_arith();
        logic [3:0] ops [4] = '{OP_INC, OP_DEC, OP_ADD, OP_SUB};
        logic [31:0] ep [4] = '{0, 32'hffff_ffff, 32'h0000_000f,
                                32'hffff_ffef};
        send(OP_LOAD_ADDR, 1'b1, 4'h5, 32'hffff_ffff);
        foreach (ops[i]) begin
            send(ops[i], 1'b1, 4'h5, 32'h0000_0010 << i / 3);
            get(4'h5, ep[i]);
        end
        send(OP_FROM_LEGACY, 1'b1, 4'h7, 32'h0000_2468);
        chk("from_legacy", 32'h0000_2468 + `LEGACY_OFFSET, result_data_reg);
        send(OP_TO_LEGACY, 1'b1, 4'h7, 32'h0000_2468);
        chk("to_legacy", 32'h0000_2468 - `LEGACY_OFFSET, result_data_reg);
        chk("result_valid_reg", 1, result_valid_reg);
    endtask : t_arith

    initial begin
        rstn = 0;
        {req_valid, req_direct, req_op, ptr_a, ptr_b, req_mode} = '0;
        {const_offset, operand_addr, operand_data, offset_data_reg} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("outputs_after_reset", 0, {mem_req_reg, result_valid_reg,
            illegal_reg, cmp_eq_reg, cmp_lt_reg, cmp_gt_reg});
        get(4'h9, `PTR_RESET);
        t_load();
        t_indirect();
        t_refuse();
        t_move_cmp();
        t_arith();
        print_verdict();
    end
endmodule : index_register_address_unit_tb
`default_nettype wire
